//--- design/pin_readback_defines.svh
// register indices, byte-address scaling, field positions and reset values of the pin readback block
//
// Notes on behaviour
// - group 3 read gives six pin levels
// - group 4 read gives eight pin levels
// - group 5 gives four levels, top zero
// - group 6 read follows all eight pins
// - group A read mirrors eight pins, unreset
// - group B read gives pin n bit
// - group C read gives pin n bit
// - group D readback register exists, eight pins
// - group E read gives pin n bit
// - group F read gives pin n bit
// - group G readback holds five pins
// - group 1 output latch, read/write, reset zero
`ifndef PIN_READBACK_DEFINES_SVH
`define PIN_READBACK_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_G3 16'hff52
`define IDX_G4 16'hff53
`define IDX_G5 16'hff54
`define IDX_G6 16'hff55
`define IDX_GA 16'hff59
`define IDX_GB 16'hff5a
`define IDX_GC 16'hff5b
`define IDX_GD 16'hff5c
`define IDX_GE 16'hff5d
`define IDX_GF 16'hff5e
`define IDX_GG 16'hff5f
`define IDX_G1_OUT 16'hff60

// byte address layout: index above two zero lane bits
`define ADDR_W 18
`define IDX_LSB 2

// pin group widths
`define G3_W 6
`define G4_W 8
`define G5_W 4
`define G6_W 8
`define G8_W 8
`define GG_W 5
// all synchronised pins packed in one vector
`define PIN_TOTAL_W 79

// group 1 latch reset value
`define G1_OUT_RST 8'h00

`endif

//--- design/pin_readback_pkg.sv
// types shared by the pin readback block
package pin_readback_pkg;

    // one-hot states of the bus answer sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_t;

    // which register an index selects
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_G3 = 4'h1,
        SEL_G4 = 4'h2,
        SEL_G5 = 4'h3,
        SEL_G6 = 4'h4,
        SEL_GA = 4'h5,
        SEL_GB = 4'h6,
        SEL_GC = 4'h7,
        SEL_GD = 4'h8,
        SEL_GE = 4'h9,
        SEL_GF = 4'ha,
        SEL_GG = 4'hb,
        SEL_G1_OUT = 4'hc
    } reg_sel_t;

endpackage : pin_readback_pkg

//--- design/pin_sync2.sv
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
`include "pin_readback_defines.svh"
module pin_sync2 import pin_readback_pkg::*; (
    input wire logic clk, // system clock
    input wire logic [`PIN_TOTAL_W-1:0] async_in, // raw pin levels
    output logic [`PIN_TOTAL_W-1:0] sync_out // levels safe for core logic
);

    logic [`PIN_TOTAL_W-1:0] meta; // first stage, read only by second stage
    logic [`PIN_TOTAL_W-1:0] next_meta; // next first stage
    logic [`PIN_TOTAL_W-1:0] next_sync; // next second stage

    // no reset: content follows the pins, there is no defined initial value
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    // both stages register every edge
    always_ff @(posedge clk) begin
        meta <= next_meta;
        sync_out <= next_sync;
    end

endmodule : pin_sync2

//--- design/apb_answer_seq.sv
// apb answer sequencer: one wait-free access cycle after each setup
`timescale 1ns/1ps
`include "pin_readback_defines.svh"
module apb_answer_seq import pin_readback_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    output logic pready, // ready, straight from a state flop
    output logic setup_seen // high in the setup cycle only
);

    apb_state_t state; // current state
    apb_state_t next_state; // next state

    // a setup cycle is select without enable while idle
    assign setup_seen = psel && !penable && (state == ST_IDLE);

    // next state: answer in the first access cycle, then back to idle
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (setup_seen) begin
                    next_state = ST_ACCESS; // ready for the coming access cycle
                end
            end
            ST_ACCESS: begin
                next_state = ST_IDLE; // transfer completes at this edge
            end
            default: begin
                next_state = ST_IDLE; // recover from an illegal code
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ready is the access bit of the one-hot code
    assign pready = state[1];

endmodule : apb_answer_seq

//--- design/pin_readback_top.sv
// pin level readback registers and group 1 output latch behind an apb slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pin_readback_defines.svh"
module pin_readback_top import pin_readback_pkg::*; (
    input wire logic CORE_CLK, // system clock, 40 MHz
    input wire logic RST, // synchronous reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction, high for write
    input wire logic [`ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data, registered
    output logic PREADY, // apb ready, registered
    output logic PSLVERR, // apb error, registered
    input wire logic [`G3_W-1:0] G3_PINS, // group 3 pin levels
    input wire logic [`G4_W-1:0] G4_PINS, // group 4 pin levels
    input wire logic [`G5_W-1:0] G5_PINS, // group 5 pin levels
    input wire logic [`G6_W-1:0] G6_PINS, // group 6 pin levels
    input wire logic [`G8_W-1:0] GA_PINS, // group A pin levels
    input wire logic [`G8_W-1:0] GB_PINS, // group B pin levels
    input wire logic [`G8_W-1:0] GC_PINS, // group C pin levels
    input wire logic [`G8_W-1:0] GD_PINS, // group D pin levels
    input wire logic [`G8_W-1:0] GE_PINS, // group E pin levels
    input wire logic [`G8_W-1:0] GF_PINS, // group F pin levels
    input wire logic [`GG_W-1:0] GG_PINS, // group G pin levels
    output logic [7:0] GROUP1_OUT // group 1 output latch value
);

    // decode a byte address into a register select
    function automatic reg_sel_t decode_addr(input logic [`ADDR_W-1:0] addr);
        logic [15:0] idx;
        idx = addr[`ADDR_W-1:`IDX_LSB];
        decode_addr = SEL_NONE;
        // only aligned words decode; a stray lane offset falls to no register
        if (addr[`IDX_LSB-1:0] == 2'h0) begin
            case (idx)
                `IDX_G3: decode_addr = SEL_G3;
                `IDX_G4: decode_addr = SEL_G4;
                `IDX_G5: decode_addr = SEL_G5;
                `IDX_G6: decode_addr = SEL_G6;
                `IDX_GA: decode_addr = SEL_GA;
                `IDX_GB: decode_addr = SEL_GB;
                `IDX_GC: decode_addr = SEL_GC;
                `IDX_GD: decode_addr = SEL_GD;
                `IDX_GE: decode_addr = SEL_GE;
                `IDX_GF: decode_addr = SEL_GF;
                `IDX_GG: decode_addr = SEL_GG;
                `IDX_G1_OUT: decode_addr = SEL_G1_OUT;
                default: decode_addr = SEL_NONE;
            endcase
        end
    endfunction : decode_addr

    // synchronised pin levels per group
    logic [`PIN_TOTAL_W-1:0] pins_raw; // all raw pins packed
    logic [`PIN_TOTAL_W-1:0] pins_sync; // all synchronised pins
    logic [`G3_W-1:0] pins_group3_level; // group 3 levels
    logic [`G4_W-1:0] pins_group4_level; // group 4 levels
    logic [`G5_W-1:0] pins_group5_level; // group 5 levels
    logic [`G6_W-1:0] pins_group6_level; // group 6 levels
    logic [`G8_W-1:0] pins_groupa_level; // group A levels
    logic [`G8_W-1:0] pins_groupb_level; // group B levels
    logic [`G8_W-1:0] pins_groupc_level; // group C levels
    logic [`G8_W-1:0] pins_groupd_level; // group D levels
    logic [`G8_W-1:0] pins_groupe_level; // group E levels
    logic [`G8_W-1:0] pins_groupf_level; // group F levels
    logic [`GG_W-1:0] pins_groupg_level; // group G levels

    // bus state
    logic setup_seen; // setup cycle of a fresh transfer
    logic xfer_done; // access edge at which the transfer completes
    reg_sel_t sel; // decoded register of the current address
    logic [7:0] group1_output_latch; // group 1 output latch
    logic [7:0] next_latch; // next latch value
    logic [31:0] next_prdata; // next read data
    logic next_pslverr; // next error flag
    logic pslverr_q; // error flag register

    // pack raw pins, group 3 in the low bits
    assign pins_raw = {GG_PINS, GF_PINS, GE_PINS, GD_PINS, GC_PINS, GB_PINS,
                       GA_PINS, G6_PINS, G5_PINS, G4_PINS, G3_PINS};

    // every pin level crosses two flops before any read sees it
    pin_sync2 u_sync (
        .clk(CORE_CLK),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // unpack synchronised levels, bit n of each group is pin n
    // groups sit back to back, group 3 in the lowest bits
    assign pins_group3_level = pins_sync[5:0];
    assign pins_group4_level = pins_sync[13:6];
    assign pins_group5_level = pins_sync[17:14];
    assign pins_group6_level = pins_sync[25:18];
    assign pins_groupa_level = pins_sync[33:26];
    assign pins_groupb_level = pins_sync[41:34];
    assign pins_groupc_level = pins_sync[49:42];
    assign pins_groupd_level = pins_sync[57:50];
    assign pins_groupe_level = pins_sync[65:58];
    assign pins_groupf_level = pins_sync[73:66];
    assign pins_groupg_level = pins_sync[78:74];

    // handshake sequencer; ready follows every setup by one cycle
    // no wait states: every register answers from a flop, nothing to stall for
    apb_answer_seq u_seq (
        .clk(CORE_CLK),
        .rst(RST),
        .psel(PSEL),
        .penable(PENABLE),
        .pready(PREADY),
        .setup_seen(setup_seen)
    );

    assign sel = decode_addr(PADDR);
    assign xfer_done = PSEL && PENABLE && PREADY;

    // read data and error are decided in setup and held through access;
    // pins are sampled once, so a read returns one coherent snapshot
    always_comb begin
        next_prdata = PRDATA;
        next_pslverr = pslverr_q;
        if (setup_seen) begin
            next_prdata = 32'h0;
            next_pslverr = (sel == SEL_NONE);
            if (!PWRITE) begin
                case (sel)
                    SEL_G3: next_prdata = {26'h0, pins_group3_level};
                    SEL_G4: next_prdata = {24'h0, pins_group4_level};
                    SEL_G5: next_prdata = {28'h0, pins_group5_level};
                    SEL_G6: next_prdata = {24'h0, pins_group6_level};
                    SEL_GA: next_prdata = {24'h0, pins_groupa_level};
                    SEL_GB: next_prdata = {24'h0, pins_groupb_level};
                    SEL_GC: next_prdata = {24'h0, pins_groupc_level};
                    SEL_GD: next_prdata = {24'h0, pins_groupd_level};
                    SEL_GE: next_prdata = {24'h0, pins_groupe_level};
                    SEL_GF: next_prdata = {24'h0, pins_groupf_level};
                    SEL_GG: next_prdata = {27'h0, pins_groupg_level};
                    SEL_G1_OUT: next_prdata = {24'h0, group1_output_latch};
                    default: next_prdata = 32'h0; // unmapped reads as zero
                endcase
            end
        end else if (xfer_done) begin
            next_pslverr = 1'b0; // error only stands through its access cycle
        end
    end

    // latch takes a write only at the completing edge with lane 0 strobed;
    // writes to readback registers fall through and change nothing
    always_comb begin
        next_latch = group1_output_latch;
        if (xfer_done && PWRITE && PSTRB[0] && (sel == SEL_G1_OUT)) begin
            next_latch = PWDATA[7:0];
        end
    end

    // bus answer registers
    // reset leaves the answer quiet: no data, no error
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            PRDATA <= next_prdata;
            pslverr_q <= next_pslverr;
        end
    end

    // output latch register, cleared by reset
    // a mid-run reset drops whatever software left in the latch
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            group1_output_latch <= `G1_OUT_RST;
        end else begin
            group1_output_latch <= next_latch;
        end
    end

    assign PSLVERR = pslverr_q;
    assign GROUP1_OUT = group1_output_latch;

    // checks: sequences of one transfer
    sequence s_setup_read(reg_sel_t s);
        setup_seen && !PWRITE && (sel == s);
    endsequence

    sequence s_write_done(reg_sel_t s);
        xfer_done && PWRITE && PSTRB[0] && (sel == s);
    endsequence

    // pins reach the register side after exactly two edges
    a_sync_two_stage: assert property (@(posedge CORE_CLK) disable iff (RST)
        ##2 pins_sync == $past(pins_raw, 2))
        else $error("pin level not delayed two cycles");

    a_read_group3: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_G3) |=> PRDATA == {26'h0, $past(pins_group3_level)})
        else $error("group 3 read mismatch");

    a_read_group5: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_G5) |=> PRDATA == {28'h0, $past(pins_group5_level)})
        else $error("group 5 read mismatch");

    a_read_groupb: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GB) |=> PRDATA[7:0] == $past(pins_groupb_level))
        else $error("group B read mismatch");

    a_read_groupg: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GG) |=> PRDATA == {27'h0, $past(pins_groupg_level)})
        else $error("group G read mismatch");

    // remaining groups: levels in place, unused upper bits zero
    // each read returns the level snapped at its setup edge
    a_read_group4: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_G4) |=> PRDATA == {24'h0, $past(pins_group4_level)})
        else $error("group 4 read mismatch");

    a_read_group6: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_G6) |=> PRDATA == {24'h0, $past(pins_group6_level)})
        else $error("group 6 read mismatch");

    a_read_groupa: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GA) |=> PRDATA == {24'h0, $past(pins_groupa_level)})
        else $error("group A read mismatch");

    a_read_groupc: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GC) |=> PRDATA == {24'h0, $past(pins_groupc_level)})
        else $error("group C read mismatch");

    a_read_groupd: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GD) |=> PRDATA == {24'h0, $past(pins_groupd_level)})
        else $error("group D read mismatch");

    a_read_groupe: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GE) |=> PRDATA == {24'h0, $past(pins_groupe_level)})
        else $error("group E read mismatch");

    a_read_groupf: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_GF) |=> PRDATA == {24'h0, $past(pins_groupf_level)})
        else $error("group F read mismatch");

    a_latch_reset: assert property (@(posedge CORE_CLK)
        RST |=> GROUP1_OUT == 8'h00)
        else $error("latch not cleared by reset");

    a_latch_write: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_write_done(SEL_G1_OUT) |=> GROUP1_OUT == $past(PWDATA[7:0]))
        else $error("latch write lost");

    a_latch_readback: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_setup_read(SEL_G1_OUT) |=> PRDATA == {24'h0, $past(GROUP1_OUT)})
        else $error("latch read mismatch");

    a_ro_write_ignored: assert property (@(posedge CORE_CLK) disable iff (RST)
        xfer_done && PWRITE && (sel != SEL_G1_OUT) |=> $stable(GROUP1_OUT))
        else $error("readback write changed state");

    a_ready_one_cycle: assert property (@(posedge CORE_CLK) disable iff (RST)
        setup_seen |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after setup");

    a_unmapped_error: assert property (@(posedge CORE_CLK) disable iff (RST)
        setup_seen && (sel == SEL_NONE) |=> PSLVERR && PREADY)
        else $error("unmapped access without error");

    // refused reads hand back an all-zero word
    a_unmapped_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        setup_seen && (sel == SEL_NONE) |=> PRDATA == 32'h0)
        else $error("unmapped read returned data");

    // mapped aligned words, readback writes included, answer without error
    a_mapped_no_error: assert property (@(posedge CORE_CLK) disable iff (RST)
        setup_seen && (sel != SEL_NONE) |=> !PSLVERR && PREADY)
        else $error("mapped access answered with error");

    // error stands for its access cycle only
    a_error_one_cycle: assert property (@(posedge CORE_CLK) disable iff (RST)
        PSLVERR |-> PREADY ##1 !PSLVERR)
        else $error("error flag outlived its access cycle");

    // a write carries no read data back
    a_write_no_data: assert property (@(posedge CORE_CLK) disable iff (RST)
        setup_seen && PWRITE |=> PRDATA == 32'h0)
        else $error("write answered with read data");

    // a latch write without lane 0 strobed leaves the latch alone
    a_latch_strobe_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        xfer_done && PWRITE && !PSTRB[0] |=> $stable(GROUP1_OUT))
        else $error("unstrobed write changed latch");

    // read data holds between setups; the reset cycle itself is left out
    // because reset clears the word without a setup
    a_rdata_holds: assert property (@(posedge CORE_CLK) disable iff (RST)
        !setup_seen && !RST |=> $stable(PRDATA))
        else $error("read data changed outside setup");

    // ready never rises without a setup the cycle before
    a_ready_needs_setup: assert property (@(posedge CORE_CLK) disable iff (RST)
        $rose(PREADY) |-> $past(setup_seen))
        else $error("ready rose without setup");

endmodule : pin_readback_top

//--- dv/pin_field_model.sv
// external pin levels of every group, loaded one group per clock edge
`timescale 1ns/1ps
`include "pin_readback_defines.svh"
module pin_field_model import pin_readback_pkg::*; (
    input wire logic clk, // system clock
    input wire logic set_en, // load one group at this edge
    input wire logic [3:0] set_grp, // group index, 0 is group 3, 10 is group G
    input wire logic [7:0] set_val, // new levels for that group
    output logic [`G3_W-1:0] g3, // group 3 pins
    output logic [`G4_W-1:0] g4, // group 4 pins
    output logic [`G5_W-1:0] g5, // group 5 pins
    output logic [`G6_W-1:0] g6, // group 6 pins
    output logic [`G8_W-1:0] ga, // group A pins
    output logic [`G8_W-1:0] gb, // group B pins
    output logic [`G8_W-1:0] gc, // group C pins
    output logic [`G8_W-1:0] gd, // group D pins
    output logic [`G8_W-1:0] ge, // group E pins
    output logic [`G8_W-1:0] gf, // group F pins
    output logic [`GG_W-1:0] gg // group G pins
);
    // one byte per group; pins start low so nothing floats at time zero
    logic [7:0] lvl [11] = '{default: 8'h00};

    // pins move only on a load, like an outside driver; bad indices are dropped
    always @(posedge clk) begin
        if (set_en && set_grp < 4'hb) begin
            lvl[set_grp] <= set_val;
        end
    end

    // narrow groups drive only their low bits
    assign g3 = lvl[0][`G3_W-1:0];
    assign g4 = lvl[1];
    assign g5 = lvl[2][`G5_W-1:0];
    assign g6 = lvl[3];
    assign ga = lvl[4];
    assign gb = lvl[5];
    assign gc = lvl[6];
    assign gd = lvl[7];
    assign ge = lvl[8];
    assign gf = lvl[9];
    assign gg = lvl[10][`GG_W-1:0];
endmodule : pin_field_model

//--- dv/test_pin_readback_top.sv
// self-checking bench: pin readback registers and group 1 latch over apb
`timescale 1ns/1ps
`include "pin_readback_defines.svh"
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module test_pin_readback_top import pin_readback_pkg::*; ;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, set_en; // bus and control
    logic [17:0] paddr; // byte address
    logic [31:0] pwdata, prdata, d; // bus data, last read
    logic [3:0] pstrb, set_grp; // strobes, group to load
    logic [7:0] g1_out, set_val; // latch output, new pin levels
    logic e; // last error flag
    logic [`G8_W-1:0] pa, pb, pc, pd, pe, pf, p4, p6; // wide groups
    logic [`G3_W-1:0] p3; // group 3
    logic [`G5_W-1:0] p5; // group 5
    logic [`GG_W-1:0] pg; // group G
    int err_total = 0; // mismatches
    int tests_run = 0; // comparisons
    logic [7:0] cur [11]; // levels the pins now carry
    // byte address and width of each group, in group index order
    logic [17:0] adr [11] = '{{`IDX_G3, 2'b00}, {`IDX_G4, 2'b00}, {`IDX_G5, 2'b00}, {`IDX_G6, 2'b00},
        {`IDX_GA, 2'b00}, {`IDX_GB, 2'b00}, {`IDX_GC, 2'b00}, {`IDX_GD, 2'b00}, {`IDX_GE, 2'b00},
        {`IDX_GF, 2'b00}, {`IDX_GG, 2'b00}};
    int wid [11] = '{`G3_W, `G4_W, `G5_W, `G6_W, 8, 8, 8, 8, 8, 8, `GG_W};
    localparam logic [17:0] LATCH = {`IDX_G1_OUT, 2'b00}; // group 1 latch address

    pin_readback_top DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .G3_PINS(p3), .G4_PINS(p4), .G5_PINS(p5), .G6_PINS(p6), .GA_PINS(pa), .GB_PINS(pb), .GC_PINS(pc),
        .GD_PINS(pd), .GE_PINS(pe), .GF_PINS(pf), .GG_PINS(pg), .GROUP1_OUT(g1_out));
    pin_field_model pins (.clk(clk), .set_en(set_en), .set_grp(set_grp), .set_val(set_val), .g3(p3),
        .g4(p4), .g5(p5), .g6(p6), .ga(pa), .gb(pb), .gc(pc), .gd(pd), .ge(pe), .gf(pf), .gg(pg));

    // free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] st);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            err_total++;
            $display("unexpected ready wait expired at %h", a);
            finish_test();
        end
    endtask : apb

    // the outside world moves one group to new levels
    task automatic set_pins(input int g, input logic [7:0] v);
        @(posedge clk);
        set_en <= 1'b1;
        set_grp <= 4'(g);
        set_val <= v;
        cur[g] = v;
        @(posedge clk);
        set_en <= 1'b0;
    endtask : set_pins

    // what a read of group g should give: pin bits in place, rest zero
    function automatic logic [31:0] expv(int g);
        return {24'h0, cur[g] & 8'((9'h1 << wid[g]) - 9'h1)};
    endfunction : expv

    // every group, distinct values per group, twice with inverted bits
    task automatic t_readback();
        foreach (cur[g]) set_pins(g, 8'ha5 ^ 8'(g * 17));
        repeat (4) @(posedge clk);
        foreach (cur[g]) begin
            apb(1'b0, adr[g], 32'h0, 4'h0);
            `CHK("group level", expv(g), d)
            `CHK("group error", 1'b0, e)
            set_pins(g, ~cur[g]);
            repeat (4) @(posedge clk);
            apb(1'b0, adr[g], 32'h0, 4'h0);
            `CHK("group level inverted", expv(g), d)
        end
    endtask : t_readback

    // latch load, upper data dropped, strobe off ignored, reset mid-run clears
    task automatic t_latch();
        apb(1'b1, LATCH, 32'h5a5a5ac3, 4'hf);
        @(negedge clk); // latch loads at the completing edge, settled by now
        `CHK("latch out", 8'hc3, g1_out)
        apb(1'b1, LATCH, 32'h11, 4'he);
        apb(1'b0, LATCH, 32'h0, 4'h0);
        `CHK("latch read", 32'h000000c3, d)
        `CHK("latch error", 1'b0, e)
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("latch after reset", 8'h00, g1_out)
        apb(1'b1, LATCH, 32'hff, 4'h1);
        @(negedge clk);
        `CHK("latch all ones", 8'hff, g1_out)
    endtask : t_latch

    // writes to readback places and to bad addresses change nothing
    task automatic t_no_write();
        foreach (cur[g]) begin
            apb(1'b1, adr[g], ~expv(g), 4'hf);
            `CHK("readback write error", 1'b0, e)
            apb(1'b0, adr[g], 32'h0, 4'h0);
            `CHK("readback after write", expv(g), d)
        end
        apb(1'b0, 18'h3fd58, 32'h0, 4'h0);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, d)
        apb(1'b1, LATCH + 18'h1, 32'h77, 4'hf);
        `CHK("misaligned error", 1'b1, e)
        @(negedge clk);
        `CHK("latch kept", 8'hff, g1_out)
    endtask : t_no_write

    // a read launched right after a pin change still sees the old level
    task automatic t_sync();
        logic [31:0] old;
        old = expv(0);
        set_pins(0, ~cur[0]);
        apb(1'b0, adr[0], 32'h0, 4'h0);
        `CHK("level too early", old, d)
        apb(1'b0, adr[0], 32'h0, 4'h0);
        `CHK("level settled", expv(0), d)
    endtask : t_sync

    // reset for three cycles, then the scenarios in turn
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        set_en = 1'b0;
        set_grp = '0;
        set_val = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("latch reset", 8'h00, g1_out)
        `CHK("ready idle", 1'b0, pready)
        t_readback();
        t_latch();
        t_no_write();
        t_sync();
        finish_test();
    end
endmodule : test_pin_readback_top
